// [core/lwtc_map.svh]
`ifndef LWTC_MAP_SVH
`define LWTC_MAP_SVH

// ****************************************************************
// register offsets (8-bit plain port, 5-bit address)
// ****************************************************************
`define LWTC_OFF_CTRL       5'h00
`define LWTC_OFF_CLKCFG     5'h01
`define LWTC_OFF_SEG_FIRST  5'h02
`define LWTC_OFF_SEG_LAST   5'h0F
`define LWTC_OFF_STATUS     5'h10

// ****************************************************************
// display_control_reg fields
// ****************************************************************
`define LWTC_CTRL_EN_BIT    7
`define LWTC_CTRL_FC_BIT    6
`define LWTC_CTRL_LC_BIT    5
`define LWTC_CTRL_CON_MSB   3
`define LWTC_CTRL_CON_LSB   0
`define LWTC_CTRL_MASK      8'hEF
`define LWTC_CTRL_RST       8'h00

// ****************************************************************
// waveform_clock_cfg fields
// ****************************************************************
`define LWTC_CLK_BW_MSB     7
`define LWTC_CLK_BW_LSB     6
`define LWTC_CLK_DUTY_MSB   5
`define LWTC_CLK_DUTY_LSB   4
`define LWTC_CLK_DIV_MSB    2
`define LWTC_CLK_DIV_LSB    0
`define LWTC_CLK_MASK       8'hF7
`define LWTC_CLK_RST        8'h00

// ****************************************************************
// status fields
// ****************************************************************
`define LWTC_ST_LEVEL_BIT   0
`define LWTC_ST_BOOST_BIT   1
`define LWTC_ST_PH_MSB      3
`define LWTC_ST_PH_LSB      2

// ****************************************************************
// divider: last count of each ratio (ratio minus one)
// ****************************************************************
`define LWTC_DIV_LAST_128   16'h007F
`define LWTC_DIV_LAST_256   16'h00FF
`define LWTC_DIV_LAST_512   16'h01FF
`define LWTC_DIV_LAST_1024  16'h03FF
`define LWTC_DIV_LAST_16K   16'h3FFF
`define LWTC_DIV_LAST_32K   16'h7FFF
`define LWTC_DIV_LAST_64K   16'hFFFF
`define LWTC_DIV_RESERVED   3'h7

// boost length = base period >> shift (32, 64, 128)
`define LWTC_BOOST_SH_32    5
`define LWTC_BOOST_SH_64    6
`define LWTC_BOOST_SH_128   7

// ****************************************************************
// panel geometry
// ****************************************************************
`define LWTC_SEG_REGS       14
`define LWTC_FP_COUNT       27
`define LWTC_BP_PER_FP      4

`endif

// [core/lwtc_pkg.sv]
package lwtc_pkg;

  typedef enum logic [1:0]
  {
    LWTC_DUTY_STATIC  = 2'h0,
    LWTC_DUTY_THIRD   = 2'h1,
    LWTC_DUTY_QUARTER = 2'h2,
    LWTC_DUTY_UNUSED  = 2'h3
  } lwtc_duty_t;

  typedef enum logic [1:0]
  {
    LWTC_BW_32     = 2'h0,
    LWTC_BW_64     = 2'h1,
    LWTC_BW_128    = 2'h2,
    LWTC_BW_UNUSED = 2'h3
  } lwtc_bw_t;

  // one-hot frame phase, bit j drives backplane j
  typedef enum logic [3:0]
  {
    LWTC_PH0 = 4'h1,
    LWTC_PH1 = 4'h2,
    LWTC_PH2 = 4'h4,
    LWTC_PH3 = 4'h8
  } lwtc_phase_t;

  typedef struct packed
  {
    logic        enable;
    logic        base_level;
    logic        shared_as_bp;
    logic        shared_on;
    logic [3:0]  bp_sel;
    logic [26:0] fp_on;
  } lwtc_drive_t;

  typedef struct packed
  {
    logic       low_res;
    logic [3:0] contrast_level;
  } lwtc_bias_t;

endpackage

// [core/lwtc_seg_mem.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lwtc_map.svh"

module lwtc_seg_mem
  import lwtc_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // write port
  input  wire logic         wr_en,
  input  wire logic [3:0]   wr_idx,
  input  wire logic [7:0]   wr_data,
  // read port
  input  wire logic         rd_en,
  input  wire logic [3:0]   rd_idx,
  output var  logic [7:0]   rd_data,
  // all cells, for the waveform stage
  output var  logic [111:0] all_data
);

  logic [7:0] cell_r [`LWTC_SEG_REGS];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < `LWTC_SEG_REGS; i++)
        cell_r[i] <= 8'h00;
    end
    else if (wr_en && (wr_idx < 4'(`LWTC_SEG_REGS)))
      cell_r[wr_idx] <= wr_data;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data <= 8'h00;
    else if (rd_en)
      rd_data <= (rd_idx < 4'(`LWTC_SEG_REGS)) ? cell_r[rd_idx] : 8'h00;
  end

  always_comb
  begin
    for (int i = 0; i < `LWTC_SEG_REGS; i++)
      all_data[i*8 +: 8] = cell_r[i];
  end

endmodule

`default_nettype wire

// [core/lwtc_core.sv]
// Behaviour
// - four-bit contrast code, readable and writable, 0000 strongest, 1111 weakest.
// - with fast charge, low-resistance ladder pulses once per base half period.
// - boost width code 00/01/10 gives base period /32, /64, /128.
// - duty code 00 static, 01 one-third, 10 one-quarter multiplexing.
// - shared pin is frontplane zero except in quarter duty, then fourth backplane.
// - reset clears boost width, duty and divider fields; all are read/write.
// - divider codes 000..011 divide reference clock by 128, 256, 512, 1024.
// - divider codes 100..110 divide by 16384, 32768, 65536; 111 reserved.
// - divider runs from the oscillator reference clock.
// - fourteen segment data registers; each bit switches one segment drive (here the top four bits of the last register drive nothing).
// - frame lasts one, three or four base periods by duty.
// - driver enable, cleared by reset, gates all plane outputs.
// - ladder: high current if low-current clear, low current, or pulsed boost.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lwtc_map.svh"

module lwtc_core
  import lwtc_pkg::*;
(
  // clock (oscillator reference) and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [4:0]  addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output var  logic [7:0]  rd_data,
  // panel and ladder side
  output var  lwtc_drive_t panel_drive,
  output var  lwtc_bias_t  ladder_bias
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0:    div_last = `LWTC_DIV_LAST_128;
      3'h1:    div_last = `LWTC_DIV_LAST_256;
      3'h2:    div_last = `LWTC_DIV_LAST_512;
      3'h3:    div_last = `LWTC_DIV_LAST_1024;
      3'h4:    div_last = `LWTC_DIV_LAST_16K;
      3'h5:    div_last = `LWTC_DIV_LAST_32K;
      3'h6:    div_last = `LWTC_DIV_LAST_64K;
      default: div_last = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] boost_len(input logic [15:0] last, input lwtc_bw_t bw);
    case (bw)
      LWTC_BW_32:  boost_len = (last >> `LWTC_BOOST_SH_32) + 16'h0001;
      LWTC_BW_64:  boost_len = (last >> `LWTC_BOOST_SH_64) + 16'h0001;
      LWTC_BW_128: boost_len = (last >> `LWTC_BOOST_SH_128) + 16'h0001;
      default:     boost_len = 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  ctrl_r;
  logic [7:0]  clkcfg_r;
  logic [7:0]  rd_local_r;
  logic        rd_seg_r;
  logic [7:0]  seg_rd;
  logic [111:0] seg_all;
  logic        seg_wr;
  logic        seg_rd_en;
  logic [3:0]  seg_idx;

  logic        driver_on;
  logic        fast_charge_sel;
  logic        low_current_sel;
  lwtc_bw_t    boost_width_sel;
  lwtc_duty_t  duty_sel;
  logic [2:0]  base_div_sel;

  assign driver_on       = ctrl_r[`LWTC_CTRL_EN_BIT];
  assign fast_charge_sel = ctrl_r[`LWTC_CTRL_FC_BIT];
  assign low_current_sel = ctrl_r[`LWTC_CTRL_LC_BIT];
  assign boost_width_sel = lwtc_bw_t'(clkcfg_r[`LWTC_CLK_BW_MSB:`LWTC_CLK_BW_LSB]);
  assign duty_sel        = lwtc_duty_t'(clkcfg_r[`LWTC_CLK_DUTY_MSB:`LWTC_CLK_DUTY_LSB]);
  assign base_div_sel    = clkcfg_r[`LWTC_CLK_DIV_MSB:`LWTC_CLK_DIV_LSB];

  // unused codes are stored unchanged so software reads back what it wrote
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_r <= `LWTC_CTRL_RST;
    else if (wr_en && addr == `LWTC_OFF_CTRL)
      ctrl_r <= wr_data & `LWTC_CTRL_MASK;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      clkcfg_r <= `LWTC_CLK_RST;
    else if (wr_en && addr == `LWTC_OFF_CLKCFG)
      clkcfg_r <= wr_data & `LWTC_CLK_MASK;
  end

  // ****************************************************************
  // segment data store
  // ****************************************************************
  assign seg_wr    = wr_en && addr >= `LWTC_OFF_SEG_FIRST && addr <= `LWTC_OFF_SEG_LAST;
  assign seg_rd_en = rd_en && addr >= `LWTC_OFF_SEG_FIRST && addr <= `LWTC_OFF_SEG_LAST;
  assign seg_idx   = 4'(addr - `LWTC_OFF_SEG_FIRST);

  lwtc_seg_mem u_seg_mem
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .wr_en    (seg_wr),
    .wr_idx   (seg_idx),
    .wr_data  (wr_data),
    .rd_en    (seg_rd_en),
    .rd_idx   (seg_idx),
    .rd_data  (seg_rd),
    .all_data (seg_all)
  );

  // ****************************************************************
  // base clock divider
  // ****************************************************************
  logic [15:0] cnt_r;
  logic [15:0] last;
  logic [15:0] half_last;
  logic [15:0] pos;
  logic        div_ok;
  logic        full_end;
  logic        base_lvl;
  logic        boost_active;

  assign last      = div_last(base_div_sel);
  assign half_last = last >> 1;
  assign pos       = cnt_r & half_last;
  assign div_ok    = base_div_sel != `LWTC_DIV_RESERVED;
  assign full_end  = div_ok && cnt_r >= last;
  assign base_lvl  = div_ok && cnt_r <= half_last;

  // a reserved code parks the divider, so the panel sees no edges at all
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_r <= 16'h0000;
    else if (!div_ok)
      cnt_r <= 16'h0000;
    else if (cnt_r >= last)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_r + 16'h0001;
  end

  // pulse sits at the start of each half period, where the waveform switches
  assign boost_active = div_ok && pos < boost_len(last, boost_width_sel);

  // ****************************************************************
  // frame phase
  // ****************************************************************
  lwtc_phase_t phase_r;
  lwtc_phase_t phase_nxt;

  always_comb
  begin
    phase_nxt = phase_r;
    if (full_end)
    begin
      case (phase_r)
        LWTC_PH0:
          phase_nxt = (duty_sel == LWTC_DUTY_THIRD || duty_sel == LWTC_DUTY_QUARTER)
                      ? LWTC_PH1 : LWTC_PH0;
        LWTC_PH1:
          phase_nxt = LWTC_PH2;
        LWTC_PH2:
          phase_nxt = (duty_sel == LWTC_DUTY_QUARTER) ? LWTC_PH3 : LWTC_PH0;
        default:
          phase_nxt = LWTC_PH0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_r <= LWTC_PH0;
    else
      phase_r <= phase_nxt;
  end

  // ****************************************************************
  // plane drive
  // ****************************************************************
  logic [1:0]  ph_idx;
  logic [26:0] fp_c;
  lwtc_drive_t drive_nxt;
  logic        quarter;

  assign quarter = duty_sel == LWTC_DUTY_QUARTER;

  always_comb
  begin
    case (phase_r)
      LWTC_PH1: ph_idx = 2'h1;
      LWTC_PH2: ph_idx = 2'h2;
      LWTC_PH3: ph_idx = 2'h3;
      default:  ph_idx = 2'h0;
    endcase
  end

  // bit 4*k+j of the store is frontplane k against backplane j
  always_comb
  begin
    for (int k = 0; k < `LWTC_FP_COUNT; k++)
      fp_c[k] = seg_all[k*`LWTC_BP_PER_FP + int'(ph_idx)];
  end

  always_comb
  begin
    drive_nxt = '0;
    if (driver_on)
    begin
      drive_nxt.enable       = 1'b1;
      drive_nxt.base_level   = base_lvl;
      drive_nxt.shared_as_bp = quarter;
      drive_nxt.bp_sel       = quarter ? phase_r : (phase_r & 4'h7);
      drive_nxt.fp_on        = quarter ? {fp_c[26:1], 1'b0} : fp_c;
      drive_nxt.shared_on    = quarter ? phase_r[3] : fp_c[0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      panel_drive <= '0;
    else
      panel_drive <= drive_nxt;
  end

  // ****************************************************************
  // ladder bias
  // ****************************************************************
  lwtc_bias_t bias_nxt;

  always_comb
  begin
    bias_nxt.contrast_level = ctrl_r[`LWTC_CTRL_CON_MSB:`LWTC_CTRL_CON_LSB];
    if (!low_current_sel)
      bias_nxt.low_res = 1'b1;
    else if (!fast_charge_sel)
      bias_nxt.low_res = 1'b0;
    else
      bias_nxt.low_res = boost_active;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ladder_bias <= '0;
    else
      ladder_bias <= bias_nxt;
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_local_r <= 8'h00;
      rd_seg_r   <= 1'b0;
    end
    else if (rd_en)
    begin
      rd_seg_r <= seg_rd_en;
      if (addr == `LWTC_OFF_CTRL)
        rd_local_r <= ctrl_r;
      else if (addr == `LWTC_OFF_CLKCFG)
        rd_local_r <= clkcfg_r;
      else if (addr == `LWTC_OFF_STATUS)
      begin
        rd_local_r                                  <= 8'h00;
        rd_local_r[`LWTC_ST_LEVEL_BIT]              <= base_lvl;
        rd_local_r[`LWTC_ST_BOOST_BIT]              <= boost_active;
        rd_local_r[`LWTC_ST_PH_MSB:`LWTC_ST_PH_LSB] <= ph_idx;
      end
      else
        rd_local_r <= 8'h00;
    end
  end

  assign rd_data = rd_seg_r ? seg_rd : rd_local_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic ctrl_wr;
  logic clk_wr;
  assign ctrl_wr = wr_en && addr == `LWTC_OFF_CTRL;
  assign clk_wr  = wr_en && addr == `LWTC_OFF_CLKCFG;

  // the checks look backwards over whole periods, so they need counters, not long repeats
  logic [7:0] gap_r;
  logic       gap_ok_r;
  logic [7:0] quiet_r;

  // cycles since the last base period end; gap_ok_r drops on any clock config write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_r    <= 8'h00;
      gap_ok_r <= 1'b0;
    end
    else if (full_end)
    begin
      gap_r    <= 8'h00;
      gap_ok_r <= !clk_wr;
    end
    else
    begin
      gap_r    <= (gap_r == 8'hFF) ? gap_r : gap_r + 8'h01;
      gap_ok_r <= gap_ok_r && !clk_wr;
    end
  end

  // cycles since the last control or clock config write, saturating
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      quiet_r <= 8'h00;
    else if (clk_wr || ctrl_wr)
      quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF)
      quiet_r <= quiet_r + 8'h01;
  end

  property p_reset_clear;
    $past(!reset_n) |-> clkcfg_r == 8'h00 && !driver_on;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared by reset");

  property p_contrast;
    ctrl_wr ##1 !ctrl_wr |=> ladder_bias.contrast_level == $past(wr_data[3:0], 2);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast code not passed to ladder");

  property p_boost_width;
    $fell(ladder_bias.low_res) && low_current_sel && fast_charge_sel && quiet_r >= 8'h08
      && base_div_sel == 3'h0 && boost_width_sel == LWTC_BW_32
      |-> $past(ladder_bias.low_res, 4) && $past(ladder_bias.low_res, 3)
          && $past(ladder_bias.low_res, 2) && $past(ladder_bias.low_res)
          && !$past(ladder_bias.low_res, 5);
  endproperty
  a_boost_width: assert property (p_boost_width) else $error("boost pulse not 4 cycles");

  property p_boost_repeat;
    $rose(ladder_bias.low_res) && low_current_sel && fast_charge_sel
      && base_div_sel == 3'h0 && quiet_r >= 8'h46
      |-> $past(ladder_bias.low_res, 64) && !$past(ladder_bias.low_res, 65);
  endproperty
  a_boost_repeat: assert property (p_boost_repeat) else $error("boost not once per half period");

  property p_high_current;
    !low_current_sel && reset_n ##1 !low_current_sel |-> ladder_bias.low_res;
  endproperty
  a_high_current: assert property (p_high_current) else $error("ladder not high current");

  property p_low_current;
    (low_current_sel && !fast_charge_sel) [*2] |-> !ladder_bias.low_res;
  endproperty
  a_low_current: assert property (p_low_current) else $error("ladder not low current");

  property p_driver_off;
    !driver_on ##1 !driver_on |-> panel_drive == '0;
  endproperty
  a_driver_off: assert property (p_driver_off) else $error("plane drive while disabled");

  property p_div_128;
    base_div_sel == 3'h0 && gap_ok_r |-> full_end == (gap_r == 8'h7F);
  endproperty
  a_div_128: assert property (p_div_128) else $error("base period not 128 cycles");

  property p_quarter_wrap;
    full_end && quarter && phase_r == LWTC_PH3 |=> phase_r == LWTC_PH0;
  endproperty
  a_quarter_wrap: assert property (p_quarter_wrap) else $error("quarter frame did not wrap");

  property p_third_wrap;
    full_end && duty_sel == LWTC_DUTY_THIRD && phase_r == LWTC_PH2 |=> phase_r == LWTC_PH0;
  endproperty
  a_third_wrap: assert property (p_third_wrap) else $error("third frame did not wrap");

  property p_shared_pin;
    driver_on && quarter ##1 driver_on && quarter
      |-> panel_drive.shared_as_bp && panel_drive.shared_on == panel_drive.bp_sel[3];
  endproperty
  a_shared_pin: assert property (p_shared_pin) else $error("shared pin not backplane");

  property p_readback;
    clk_wr ##1 (rd_en && addr == `LWTC_OFF_CLKCFG)
      |=> rd_data == ($past(wr_data, 2) & `LWTC_CLK_MASK);
  endproperty
  a_readback: assert property (p_readback) else $error("clock config readback wrong");

  c_quarter_frame: cover property (full_end && quarter && phase_r == LWTC_PH3);
  c_boost_pulse:   cover property ($rose(ladder_bias.low_res) && fast_charge_sel);
  c_reserved_div:  cover property (clk_wr && wr_data[2:0] == 3'h7);
  c_seg_read:      cover property (rd_seg_r);

endmodule

`default_nettype wire

// [verification/lwtc_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none

module lwtc_panel_model
  import lwtc_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // measuring window from the bench
  input  wire logic             clear,
  input  wire logic             count_en,
  // lines that reach the glass
  input  wire lwtc_drive_t      panel_drive,
  input  wire lwtc_bias_t       ladder_bias,
  // per-line on-cycle totals: base, boost, bp0, bp3, fp0, shared pin, any drive
  output var  logic [6:0][31:0] cnt
);
  logic [6:0] seen;

  // ****************************************************************
  // passive glass: it only integrates what each line carries
  // ****************************************************************
  assign seen = {panel_drive != '0, panel_drive.shared_on, panel_drive.fp_on[0],
                 panel_drive.bp_sel[3], panel_drive.bp_sel[0], ladder_bias.low_res,
                 panel_drive.base_level};

  always_ff @(posedge clk or negedge reset_n)
  begin
    for (int i = 0; i < 7; i++)
    begin
      if (!reset_n || clear)
        cnt[i] <= '0;
      else if (count_en && seen[i])
        cnt[i] <= cnt[i] + 32'h1;
    end
  end
endmodule

`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lwtc_map.svh"

module tb_top
  import lwtc_pkg::*;
();
  typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] q;} lwtc_row_t;
  typedef struct {logic [7:0] cfg; logic [31:0] win, bp0, bp3, fp0, sh;} lwtc_duty_row_t;

  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic [4:0]       addr = 5'h00;
  logic [7:0]       wr_data = 8'h00;
  logic             wr_en = 1'b0;
  logic             rd_en = 1'b0;
  logic [7:0]       rd_data;
  lwtc_drive_t      panel_drive;
  lwtc_bias_t       ladder_bias;
  logic             clear = 1'b0;
  logic             count_en = 1'b0;
  logic [6:0][31:0] cnt;
  int               miscompares = 0;
  int               compares = 0;
  int               ratio;

  // reserved bits read as zero, unused codes read back as written
  lwtc_row_t rows[6] = '{
    '{5'h01, 8'hFF, 8'hF7},
    '{5'h01, 8'h26, 8'h26},
    '{5'h00, 8'hFF, 8'hEF},
    '{5'h02, 8'hA5, 8'hA5},
    '{5'h0F, 8'h3C, 8'h3C},
    '{5'h11, 8'hFF, 8'h00}};
  // duty 11 behaves as static
  lwtc_duty_row_t duty[4] = '{
    '{8'h10, 32'h180, 32'h80, 32'h0, 32'h80, 32'h80},
    '{8'h20, 32'h200, 32'h80, 32'h80, 32'h0, 32'h80},
    '{8'h00, 32'h80, 32'h80, 32'h0, 32'h80, 32'h80},
    '{8'h30, 32'h80, 32'h80, 32'h0, 32'h80, 32'h80}};

  always #50 clk = ~clk;

  lwtc_core lwtc_core_i (
    .clk         (clk),
    .reset_n     (reset_n),
    .addr        (addr),
    .wr_data     (wr_data),
    .wr_en       (wr_en),
    .rd_en       (rd_en),
    .rd_data     (rd_data),
    .panel_drive (panel_drive),
    .ladder_bias (ladder_bias)
  );

  lwtc_panel_model lwtc_panel_model_i (
    .clk         (clk),
    .reset_n     (reset_n),
    .clear       (clear),
    .count_en    (count_en),
    .panel_drive (panel_drive),
    .ladder_bias (ladder_bias),
    .cnt         (cnt)
  );

  // ****************************************************************
  // bus cycles and comparisons
  // ****************************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // write and read back with no gap between the strobes
  task automatic wr_rd(input logic [4:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp({24'h0, rd_data}, {24'h0, exp});
  endtask

  task automatic chk_reg(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp({24'h0, rd_data}, {24'h0, exp});
  endtask

  // window of n clock samples seen by the glass model
  task automatic measure(input int n);
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    count_en <= 1'b1;
    repeat (n) @(posedge clk);
    count_en <= 1'b0;
    #1;
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // longest run is about 61k cycles
  initial
  begin
    repeat (80000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    chk_reg(`LWTC_OFF_CTRL, 8'h00);
    chk_reg(`LWTC_OFF_CLKCFG, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr_rd(rows[i].a, rows[i].d, rows[i].q);
    end
    wr(`LWTC_OFF_SEG_FIRST, 8'h01);
    wr(`LWTC_OFF_SEG_LAST, 8'h00);
    wr(`LWTC_OFF_CTRL, 8'h8A);
    repeat (2) @(posedge clk);
    #1;
    cmp({28'h0, ladder_bias.contrast_level}, 32'hA);
    wr(`LWTC_OFF_CTRL, 8'h60);
    wr(`LWTC_OFF_CLKCFG, 8'h20);
    measure(256);
    cmp(cnt[6], 32'h0);
    wr(`LWTC_OFF_CTRL, 8'hE0);
    for (int w = 0; w < 4; w++)
    begin
      wr(`LWTC_OFF_CLKCFG, 8'(w << 6));
      repeat (128) @(posedge clk);
      measure(256);
      cmp(cnt[1], (w == 3) ? 32'h0 : (32'h10 >> w));
      cmp(cnt[0], 32'h80);
    end
    wr(`LWTC_OFF_CTRL, 8'hC0);
    measure(256);
    cmp(cnt[1], 32'h100);
    wr(`LWTC_OFF_CTRL, 8'hA0);
    measure(256);
    cmp(cnt[1], 32'h0);
    wr(`LWTC_OFF_CTRL, 8'h80);
    for (int d = 0; d < 5; d++)
    begin
      ratio = (d == 4) ? 16384 : (128 << d);
      wr(`LWTC_OFF_CLKCFG, 8'(d));
      repeat (ratio) @(posedge clk);
      measure(2 * ratio);
      cmp(cnt[0], 32'(ratio));
    end
    wr(`LWTC_OFF_CLKCFG, 8'h07);
    measure(256);
    cmp(cnt[0], 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(`LWTC_OFF_CLKCFG, duty[i].cfg);
      repeat (512) @(posedge clk);
      measure(int'(duty[i].win));
      cmp(cnt[2], duty[i].bp0);
      cmp(cnt[3], duty[i].bp3);
      cmp(cnt[4], duty[i].fp0);
      cmp(cnt[5], duty[i].sh);
    end
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    chk_reg(`LWTC_OFF_CLKCFG, 8'h00);
    measure(256);
    cmp(cnt[6], 32'h0);
    print_verdict();
  end
endmodule

`default_nettype wire
